// [design/sadc_ctrl.sv]
// Purpose: successive approximation converter control with apb registers
// Assumes: cmp_hi is the comparator result for the current trial word
// Notes:   zero wait apb slave; unmapped addresses answer pslverr
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "sadc_defs.svh"
module sadc_ctrl #(
	parameter int NUM_CH      = 21,
	parameter int INSTR_CYC   = `SADC_INSTR_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              osc_tick,
	input  wire logic              sleep_mode,
	input  wire logic              cmp_hi,
	input  wire logic              ot_trip,
	output logic      [9:0]        dac_trial,
	output logic                   sample_hold,
	output logic      [NUM_CH-1:0] chan_route,
	output logic                   temp_power,
	output logic                   ot_shutdown,
	output logic                   irq
);
	initial begin
		if (INSTR_CYC < 1 || INSTR_CYC > 255) begin
			$error("INSTR_CYC out of range");
		end
	end

	////////////////////////////////////////////////////////////////////////
	sadc_ctl_if ctl ();

	sadc_tad_gen u_tad (
		.pclk     (pclk),
		.presetn  (presetn),
		.osc_tick (osc_tick),
		.ctl      (ctl.tadgen)
	);

	sadc_chan_mux #(.NUM_CH(NUM_CH)) u_mux (
		.pclk       (pclk),
		.presetn    (presetn),
		.ctl        (ctl.mux),
		.chan_route (chan_route),
		.temp_power (temp_power)
	);

	////////////////////////////////////////////////////////////////////////
	// registers and sequencer state
	sadc_pkg::sadc_state_t state_reg, state_next;
	logic                  on_reg, on_next;
	logic                  go_reg, go_next;
	logic [4:0]            chs_reg, chs_next;
	logic [2:0]            cks_reg, cks_next;
	logic                  tsen_reg, tsen_next;
	logic [9:0]            res_reg, res_next;
	logic [9:0]            sar_reg, sar_next;
	logic [3:0]            tcnt_reg, tcnt_next;
	logic [7:0]            wcnt_reg, wcnt_next;
	logic [1:0]            status_reg, status_next;
	logic [1:0]            mask_reg, mask_next;
	logic [31:0]           rd_reg, rd_next;
	logic                  err_reg, err_next;
	logic                  setup, wr, hit, done_ev, abort_ev, start_ev, go_wr_lo;
	logic [9:0]            bit_mask;

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`SADC_OFF_CTRL0, `SADC_OFF_CTRL1, `SADC_OFF_ABE, `SADC_OFF_RES_HI,
			`SADC_OFF_RES_LO, `SADC_OFF_STATUS, `SADC_OFF_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	assign setup    = psel && !penable;
	assign wr       = psel && penable && pwrite;
	assign hit      = mapped(paddr);
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && err_reg;
	assign prdata   = rd_reg;
	assign go_wr_lo = wr && (paddr == `SADC_OFF_CTRL0) && !pwdata[`SADC_C0_GO];
	// bit resolved in the current period: tcnt 1 -> b9 ... tcnt 10 -> b0
	assign bit_mask = (tcnt_reg >= 4'h1 && tcnt_reg <= `SADC_CONV_LAST) ?
		10'h200 >> (tcnt_reg - 4'h1) : 10'h000;

	assign ctl.run      = (state_reg == sadc_pkg::ST_CONV) || (state_reg == sadc_pkg::ST_ABORT);
	assign ctl.clk_sel  = cks_reg;
	assign ctl.chan     = chs_reg;
	assign ctl.route_en = on_reg;
	assign ctl.temp_en  = tsen_reg;
	assign ot_shutdown  = ot_trip;
	assign irq          = |(status_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_next = state_reg;
		sar_next   = sar_reg;
		tcnt_next  = tcnt_reg;
		wcnt_next  = wcnt_reg;
		res_next   = res_reg;
		done_ev    = 1'b0;
		abort_ev   = 1'b0;
		start_ev   = 1'b0;
		case (state_reg)
			sadc_pkg::ST_IDLE: begin
				if (on_reg && wr && (paddr == `SADC_OFF_CTRL0) && pwdata[`SADC_C0_GO]) begin
					start_ev   = 1'b1;
					tcnt_next  = 4'h0;
					sar_next   = 10'h000;
					wcnt_next  = 8'h00;
					state_next = ctl.rc_sel ? sadc_pkg::ST_RC_WAIT : sadc_pkg::ST_CONV;
				end
			end
			sadc_pkg::ST_RC_WAIT: begin
				wcnt_next = wcnt_reg + 8'h01;
				if (go_wr_lo || !on_reg) begin
					abort_ev   = 1'b1;
					tcnt_next  = 4'h0;
					state_next = sadc_pkg::ST_ABORT;
				end else if (wcnt_reg == 8'(INSTR_CYC - 1)) begin
					state_next = sadc_pkg::ST_CONV;
				end
			end
			sadc_pkg::ST_CONV: begin
				// sleep without the rc clock stops the conversion
				if (go_wr_lo || !on_reg || (sleep_mode && !ctl.rc_sel)) begin
					abort_ev   = 1'b1;
					tcnt_next  = 4'h0;
					state_next = sadc_pkg::ST_ABORT;
				end else if (ctl.tad) begin
					if (cmp_hi) begin
						sar_next = sar_reg | bit_mask;
					end
					tcnt_next = tcnt_reg + 4'h1;
					if (tcnt_reg == `SADC_CONV_LAST) begin
						res_next   = cmp_hi ? (sar_reg | bit_mask) : sar_reg;
						done_ev    = 1'b1;
						state_next = sadc_pkg::ST_IDLE;
					end
				end
			end
			sadc_pkg::ST_ABORT: begin
				if (ctl.tad) begin
					tcnt_next = tcnt_reg + 4'h1;
					if (tcnt_reg == 4'(`SADC_ABORT_TADS - 2'h1)) begin
						state_next = sadc_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				state_next = sadc_pkg::ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_comb begin
		on_next     = on_reg;
		go_next     = go_reg;
		chs_next    = chs_reg;
		cks_next    = cks_reg;
		tsen_next   = tsen_reg;
		mask_next   = mask_reg;
		status_next = status_reg;
		rd_next     = rd_reg;
		err_next    = err_reg;
		if (wr) begin
			case (paddr)
				`SADC_OFF_CTRL0: begin
					on_next  = pwdata[`SADC_C0_ON];
					chs_next = pwdata[`SADC_C0_CHS_MSB:`SADC_C0_CHS_LSB];
				end
				`SADC_OFF_CTRL1: cks_next  = pwdata[`SADC_CKS_W-1:0];
				`SADC_OFF_ABE:   tsen_next = pwdata[0];
				`SADC_OFF_STATUS: status_next = status_reg & ~pwdata[`SADC_ST_W-1:0];
				`SADC_OFF_MASK:  mask_next = pwdata[`SADC_ST_W-1:0];
				default: begin
				end
			endcase
		end
		// hardware set wins over a same-cycle software clear
		if (done_ev) begin
			status_next[`SADC_ST_DONE] = 1'b1;
		end
		if (abort_ev) begin
			status_next[`SADC_ST_ABORT] = 1'b1;
		end
		if (start_ev) begin
			go_next = 1'b1;
		end else if (done_ev || abort_ev || state_reg == sadc_pkg::ST_IDLE) begin
			go_next = 1'b0;
		end
		if (setup) begin
			err_next = !hit;
			case (paddr)
				`SADC_OFF_CTRL0:  rd_next = {25'h0, chs_reg, go_reg, on_reg};
				`SADC_OFF_CTRL1:  rd_next = {29'h0, cks_reg};
				`SADC_OFF_ABE:    rd_next = {31'h0, tsen_reg};
				`SADC_OFF_RES_HI: rd_next = {30'h0, res_reg[9:8]};
				`SADC_OFF_RES_LO: rd_next = {24'h0, res_reg[7:0]};
				`SADC_OFF_STATUS: rd_next = {30'h0, status_reg};
				`SADC_OFF_MASK:   rd_next = {30'h0, mask_reg};
				default:          rd_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= sadc_pkg::ST_IDLE;
			sar_reg    <= '0;
			tcnt_reg   <= '0;
			wcnt_reg   <= '0;
			res_reg    <= '0;
			on_reg     <= 1'b0;
			go_reg     <= 1'b0;
			chs_reg    <= '0;
			cks_reg    <= '0;
			tsen_reg   <= 1'b0;
			mask_reg   <= '0;
			status_reg <= '0;
			rd_reg     <= '0;
			err_reg    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			sar_reg    <= sar_next;
			tcnt_reg   <= tcnt_next;
			wcnt_reg   <= wcnt_next;
			res_reg    <= res_next;
			on_reg     <= on_next;
			go_reg     <= go_next;
			chs_reg    <= chs_next;
			cks_reg    <= cks_next;
			tsen_reg   <= tsen_next;
			mask_reg   <= mask_next;
			status_reg <= status_next;
			rd_reg     <= rd_next;
			err_reg    <= err_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_trial   <= '0;
			sample_hold <= 1'b1;
		end else begin
			dac_trial   <= sar_next | ((state_next == sadc_pkg::ST_CONV) ?
				(10'h200 >> (tcnt_next - 4'h1)) & {10{tcnt_next != 4'h0}} : 10'h000);
			// hold capacitor disconnected only while bits resolve
			sample_hold <= (state_next != sadc_pkg::ST_CONV);
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_conv_start;
		start_ev && !ctl.rc_sel;
	endsequence
	sequence s_rc_start;
		start_ev && ctl.rc_sel;
	endsequence
	// instruction wait steps split by the counter, so any INSTR_CYC is covered
	sequence s_rc_early;
		state_reg == sadc_pkg::ST_RC_WAIT && on_reg && !go_wr_lo &&
			wcnt_reg != 8'(INSTR_CYC - 1);
	endsequence
	sequence s_rc_due;
		state_reg == sadc_pkg::ST_RC_WAIT && on_reg && !go_wr_lo &&
			wcnt_reg == 8'(INSTR_CYC - 1);
	endsequence

	AST_DONE_FLAG: assert property (done_ev |=> status_reg[`SADC_ST_DONE] && !go_reg)
		else $error("done did not set flag and clear go");
	AST_FLAG_STICKY: assert property (status_reg[`SADC_ST_DONE] && !(wr &&
		paddr == `SADC_OFF_STATUS && pwdata[`SADC_ST_DONE]) |=> status_reg[`SADC_ST_DONE])
		else $error("done flag dropped without software clear");
	AST_ELEVEN_TAD: assert property (done_ev |-> tcnt_reg == `SADC_CONV_LAST && ctl.tad)
		else $error("conversion did not last eleven periods");
	AST_ABORT_KEEPS: assert property (abort_ev |=> $stable(res_reg) [*3])
		else $error("abort changed the result");
	AST_ABORT_WAIT: assert property (state_reg == sadc_pkg::ST_ABORT |-> tcnt_reg < 4'h2)
		else $error("abort wait exceeded two periods");
	AST_RC_DELAY: assert property (s_rc_start |=> state_reg == sadc_pkg::ST_RC_WAIT)
		else $error("rc start not delayed one instruction");
	AST_RC_HOLD: assert property (s_rc_early |=> state_reg == sadc_pkg::ST_RC_WAIT)
		else $error("rc start left the instruction wait early");
	AST_RC_LEAVE: assert property (s_rc_due |=> state_reg == sadc_pkg::ST_CONV)
		else $error("conversion did not follow the instruction wait");
	AST_START: assert property (s_conv_start |=> state_reg == sadc_pkg::ST_CONV && go_reg)
		else $error("start did not begin conversion");
	AST_IRQ: assert property (done_ev && mask_reg[`SADC_ST_DONE] |=> irq)
		else $error("completion did not raise interrupt");
	AST_OT_INDEP: assert property (ot_trip |-> ot_shutdown)
		else $error("overtemperature shutdown gated");
endmodule : sadc_ctrl
`default_nettype wire

// [common/sadc_defs.svh]
// Purpose: constants of the converter control block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   included by bare name
// Summary of operation
// - each conversion yields a 10-bit successive approximation result, right-justified
// - one 5-bit channel select field routes at most one source to sample-hold
// - 19 channels on the small variant, 21 on the large one
// - channel select value ten is the die temperature voltage
// - bit clock from system clock /2, /4, /8, /16, /32, /64 or the rc source
// - rc conversion clock is the internal oscillator divided by sixteen
// - a conversion takes eleven bit periods, msb first
// - divided sources follow the system clock; only rc is independent of it
// - temperature circuit powered only while its enable bit is set
// - temperature enable does not affect overtemperature shutdown
// - completion raises an interrupt request that can wake from sleep
// - with converter on, setting the in-progress bit starts a conversion
// - at end: clear in-progress bit, set done flag, load result pair
// - early clear aborts, keeps old result, waits two bit periods
// - with rc clock the start is delayed one extra instruction cycle
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

`define SADC_OFF_CTRL0    8'h00
`define SADC_OFF_CTRL1    8'h04
`define SADC_OFF_ABE      8'h08
`define SADC_OFF_RES_HI   8'h0c
`define SADC_OFF_RES_LO   8'h10
`define SADC_OFF_STATUS   8'h14
`define SADC_OFF_MASK     8'h18

`define SADC_C0_ON        0
`define SADC_C0_GO        1
`define SADC_C0_CHS_LSB   2
`define SADC_C0_CHS_MSB   6
`define SADC_ST_DONE      0
`define SADC_ST_ABORT     1
`define SADC_ST_W         2

`define SADC_RES_W        10
`define SADC_CHS_W        5
`define SADC_CKS_W        3
`define SADC_CH_TEMP      5'h0a
`define SADC_DIV_2        6'h01
`define SADC_DIV_4        6'h03
`define SADC_DIV_8        6'h07
`define SADC_DIV_16       6'h0f
`define SADC_DIV_32       6'h1f
`define SADC_DIV_64       6'h3f
`define SADC_RC_DIV       4'hf
`define SADC_CONV_LAST    4'ha
`define SADC_ABORT_TADS   2'h2
`define SADC_INSTR_NS     100
`define SADC_CLK_MHZ      40
`define SADC_INSTR_CYC    ((`SADC_INSTR_NS * `SADC_CLK_MHZ + 999) / 1000)

`endif

// [common/sadc_pkg.sv]
// Purpose: types of the converter control block
// Assumes: nothing
// Notes:   constants live in sadc_defs.svh
package sadc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RC_WAIT,
		ST_CONV,
		ST_ABORT
	} sadc_state_t;
endpackage : sadc_pkg

// [common/sadc_ctl_if.sv]
// Purpose: carrier between the sequencer and its two helpers
// Assumes: one clock
// Notes:   none
`timescale 1ns/100ps
`default_nettype none
interface sadc_ctl_if;
	logic       run;
	logic [2:0] clk_sel;
	logic       tad;
	logic       rc_sel;
	logic [4:0] chan;
	logic       route_en;
	logic       temp_en;
	modport seq (output run, output clk_sel, input tad, input rc_sel,
		output chan, output route_en, output temp_en);
	modport tadgen (input run, input clk_sel, output tad, output rc_sel);
	modport mux (input chan, input route_en, input temp_en);
endinterface : sadc_ctl_if
`default_nettype wire

// [design/sadc_tad_gen.sv]
// Purpose: bit period enable pulse generator
// Assumes: osc_tick is a one-cycle pulse per internal oscillator period
// Notes:   counters restart when run falls, so the first period is whole
`timescale 1ns/100ps
`default_nettype none
`include "sadc_defs.svh"
module sadc_tad_gen (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic osc_tick,
	sadc_ctl_if.tadgen ctl
);
	logic [5:0] div_reg;
	logic [5:0] div_next;
	logic [3:0] rc_reg;
	logic [3:0] rc_next;
	logic [5:0] limit;
	logic       is_rc;

	function automatic logic [5:0] div_of(input logic [2:0] sel);
		case (sel[1:0])
			2'h0:    div_of = sel[2] ? `SADC_DIV_4 : `SADC_DIV_2;
			2'h1:    div_of = sel[2] ? `SADC_DIV_16 : `SADC_DIV_8;
			2'h2:    div_of = sel[2] ? `SADC_DIV_64 : `SADC_DIV_32;
			default: div_of = `SADC_DIV_8;
		endcase
	endfunction : div_of

	////////////////////////////////////////////////////////////////////////
	assign is_rc      = (ctl.clk_sel[1:0] == 2'h3);
	assign ctl.rc_sel = is_rc;
	assign limit      = div_of(ctl.clk_sel);

	always_comb begin
		div_next = '0;
		rc_next  = '0;
		ctl.tad  = 1'b0;
		if (ctl.run && !is_rc) begin
			// counts pclk directly, so it tracks any system clock change
			div_next = (div_reg == limit) ? 6'h00 : div_reg + 6'h01;
			ctl.tad  = (div_reg == limit);
		end else if (ctl.run) begin
			rc_next = osc_tick ? rc_reg + 4'h1 : rc_reg;
			ctl.tad = osc_tick && (rc_reg == `SADC_RC_DIV);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= '0;
			rc_reg  <= '0;
		end else begin
			div_reg <= div_next;
			rc_reg  <= rc_next;
		end
	end

	AST_TAD_SINGLE: assert property (@(posedge pclk) disable iff (!presetn)
		ctl.tad |=> !ctl.tad) else $error("bit period pulse longer than one cycle");
endmodule : sadc_tad_gen
`default_nettype wire

// [design/sadc_chan_mux.sv]
// Purpose: one-hot channel route and temperature circuit power
// Assumes: the analog mux closes the switch whose bit is high
// Notes:   out-of-range selects route nothing rather than alias
`timescale 1ns/100ps
`default_nettype none
`include "sadc_defs.svh"
module sadc_chan_mux #(
	parameter int NUM_CH = 21
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	sadc_ctl_if.mux                ctl,
	output logic     [NUM_CH-1:0]  chan_route,
	output logic                   temp_power
);
	initial begin
		if (NUM_CH < 11 || NUM_CH > 32) begin
			$error("NUM_CH out of range");
		end
	end

	////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_route
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					chan_route[g] <= 1'b0;
				end else begin
					chan_route[g] <= ctl.route_en && (ctl.chan == 5'(g));
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_power <= 1'b0;
		end else begin
			temp_power <= ctl.temp_en;
		end
	end

	AST_ONE_CHANNEL: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot0(chan_route)) else $error("more than one channel routed");
	AST_TEMP_CHANNEL: assert property (@(posedge pclk) disable iff (!presetn)
		(ctl.route_en && ctl.chan == `SADC_CH_TEMP) |=> chan_route[`SADC_CH_TEMP])
		else $error("value ten did not route temperature");
	AST_TEMP_POWER: assert property (@(posedge pclk) disable iff (!presetn)
		ctl.temp_en |=> temp_power) else $error("temperature circuit not powered");
endmodule : sadc_chan_mux
`default_nettype wire

// [verif/sadc_analog_model.sv]
// Purpose: behavioural analog mux, sample-hold and comparator
// Assumes: one-hot route, sample_hold high means tracking the input
// Notes:   with nothing routed the held level wanders, never stays stale
`timescale 1ns/100ps
`default_nettype none
module sadc_analog_model #(
	parameter int NUM_CH = 21
) (
	input  wire logic              pclk,
	input  wire logic [NUM_CH-1:0] chan_route,
	input  wire logic              sample_hold,
	input  wire logic [9:0]        dac_trial,
	output logic                   cmp_hi
);
	logic [9:0] held_reg = 10'h155;
	logic [9:0] pick;
	////////////////////////////////////////////////////////////////
	// each channel carries a fixed level the bench can predict
	always_comb begin
		pick = ~held_reg;
		for (int i = 0; i < NUM_CH; i++) begin
			if (chan_route[i]) begin
				pick = 10'h2a5 ^ 10'(i * 37);
			end
		end
	end
	always_ff @(posedge pclk) begin
		if (sample_hold) begin
			held_reg <= pick;
		end
	end
	assign cmp_hi = (held_reg >= dac_trial);
endmodule : sadc_analog_model
`default_nettype wire

// [verif/testbench.sv]
// Purpose: self-checking bench of the converter control block
// Assumes: zero-wait apb slave, osc_tick every fifth pclk
// Notes:   full instruction cycle count, so the rc wait is exercised
`timescale 1ns/100ps
`default_nettype none
`include "sadc_defs.svh"
module testbench;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, sleep_mode, ot_trip;
	logic        osc_tick = 1'b0;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, cmp_hi, sample_hold, temp_power, ot_shutdown, irq;
	logic [9:0]  dac_trial;
	logic [20:0] chan_route;
	logic [31:0] last_res;
	int          fails = 0;
	int          checks = 0;
	int          osc_cnt = 0;
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		osc_cnt  <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
		osc_tick <= (osc_cnt == 4);
	end
	sadc_ctrl #(.NUM_CH(21), .INSTR_CYC(`SADC_INSTR_CYC)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
		.sleep_mode(sleep_mode), .cmp_hi(cmp_hi), .ot_trip(ot_trip), .dac_trial(dac_trial),
		.sample_hold(sample_hold), .chan_route(chan_route), .temp_power(temp_power),
		.ot_shutdown(ot_shutdown), .irq(irq));
	sadc_analog_model #(.NUM_CH(21)) far_u (.pclk(pclk), .chan_route(chan_route),
		.sample_hold(sample_hold), .dac_trial(dac_trial), .cmp_hi(cmp_hi));
	////////////////////////////////////////////////////////////////
	task complete_run;
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] aval(input int i);
		return {22'h0, 10'h2a5 ^ 10'(i * 37)};
	endfunction : aval
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			complete_run();
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask : rd
	task settle;
		@(posedge pclk);
		#1;
	endtask : settle
	////////////////////////////////////////////////////////////////
	task t_reset;
		logic [31:0] r;
		logic        e;
		for (int a = 0; a <= 8'h18; a += 4) begin
			rd(8'(a), r);
			check("reset_reg", r, 32'h0);
		end
		check("route_rst", 32'(chan_route), 32'h0);
		apb(1'b0, 8'h1c, 32'h0, r, e);
		check("unmapped_err", {31'h0, e}, 32'h1);
		wr(`SADC_OFF_RES_LO, 32'hff);
		rd(`SADC_OFF_RES_LO, r);
		check("result_ro", r, 32'h0);
	endtask : t_reset
	task t_temp;
		ot_trip <= 1'b1;
		settle();
		check("ot_no_enable", {31'h0, ot_shutdown}, 32'h1);
		wr(`SADC_OFF_ABE, 32'h1);
		settle();
		check("temp_on", {31'h0, temp_power}, 32'h1);
		ot_trip <= 1'b0;
		wr(`SADC_OFF_CTRL0, {25'h0, 5'd10, 2'b01});
		settle();
		check("temp_route", 32'(chan_route), 32'h400);
		check("ot_follow", {31'h0, ot_shutdown}, 32'h0);
		wr(`SADC_OFF_CTRL0, {25'h0, 5'd21, 2'b01});
		settle();
		check("route_range", 32'(chan_route), 32'h0);
		wr(`SADC_OFF_ABE, 32'h0);
		settle();
		check("temp_off", {31'h0, temp_power}, 32'h0);
	endtask : t_temp
	task t_refuse;
		logic [31:0] r;
		wr(`SADC_OFF_CTRL0, 32'h0);
		wr(`SADC_OFF_CTRL0, 32'h3);
		rd(`SADC_OFF_CTRL0, r);
		check("go_while_off", r, 32'h1);
		check("no_sample", {31'h0, sample_hold}, 32'h1);
	endtask : t_refuse
	task conv(input logic [2:0] cks, input logic [4:0] ch, input int lo, input int hi);
		logic [31:0] r, h;
		int          n;
		wr(`SADC_OFF_MASK, 32'h3);
		wr(`SADC_OFF_CTRL1, {29'h0, cks});
		wr(`SADC_OFF_CTRL0, {25'h0, ch, 2'b01});
		settle();
		check("route", 32'(chan_route), 32'h1 << ch);
		repeat (4) @(posedge pclk);
		wr(`SADC_OFF_CTRL0, {25'h0, ch, 2'b11});
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			settle();
			n++;
		end
		if (n >= 2000) begin
			fails++;
			complete_run();
		end
		check("conv_cycles", 32'(n >= lo && n <= hi), 32'h1);
		rd(`SADC_OFF_CTRL0, r);
		check("go_clear", r & 32'h2, 32'h0);
		rd(`SADC_OFF_STATUS, r);
		check("done_flag", r, 32'h1);
		rd(`SADC_OFF_RES_HI, h);
		rd(`SADC_OFF_RES_LO, r);
		last_res = (h << 8) | r;
		check("result", last_res, aval(ch));
		wr(`SADC_OFF_STATUS, 32'h1);
		settle();
		check("irq_clear", {31'h0, irq}, 32'h0);
	endtask : conv
	task t_abort;
		logic [31:0] r;
		wr(`SADC_OFF_MASK, 32'h0);
		wr(`SADC_OFF_CTRL1, 32'h1);
		wr(`SADC_OFF_CTRL0, {25'h0, 5'd3, 2'b01});
		wr(`SADC_OFF_CTRL0, {25'h0, 5'd3, 2'b11});
		repeat (30) @(posedge pclk);
		wr(`SADC_OFF_CTRL0, {25'h0, 5'd3, 2'b01});
		wr(`SADC_OFF_CTRL0, {25'h0, 5'd3, 2'b11});
		rd(`SADC_OFF_CTRL0, r);
		check("abort_wait", r & 32'h2, 32'h0);
		rd(`SADC_OFF_STATUS, r);
		check("abort_flag", r, 32'h2);
		check("masked_irq", {31'h0, irq}, 32'h0);
		rd(`SADC_OFF_RES_HI, r);
		check("keep_hi", r, last_res >> 8);
		wr(`SADC_OFF_MASK, 32'h3);
		settle();
		check("unmask_irq", {31'h0, irq}, 32'h1);
		wr(`SADC_OFF_STATUS, 32'h2);
		repeat (20) @(posedge pclk);
		conv(3'b001, 5'd3, 88, 88);
	endtask : t_abort
	task t_sleep;
		logic [31:0] r;
		wr(`SADC_OFF_CTRL1, 32'h0);
		wr(`SADC_OFF_CTRL0, {25'h0, 5'd3, 2'b11});
		sleep_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		sleep_mode <= 1'b0;
		rd(`SADC_OFF_STATUS, r);
		check("sleep_abort", r, 32'h2);
		rd(`SADC_OFF_RES_LO, r);
		check("sleep_keep", r, last_res & 32'hff);
		wr(`SADC_OFF_STATUS, 32'h2);
		repeat (8) @(posedge pclk);
		conv(3'b000, 5'd1, 22, 22);
		conv(3'b100, 5'd2, 44, 44);
	endtask : t_sleep
	task t_midreset;
		logic [31:0] r;
		wr(`SADC_OFF_CTRL0, {25'h0, 5'd2, 2'b11});
		repeat (10) @(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		check("rst_route", 32'(chan_route), 32'h0);
		check("rst_hold", {31'h0, sample_hold}, 32'h1);
		rd(`SADC_OFF_CTRL0, r);
		check("rst_ctrl", r, 32'h0);
		rd(`SADC_OFF_RES_LO, r);
		check("rst_res", r, 32'h0);
	endtask : t_midreset
	////////////////////////////////////////////////////////////////
	initial begin
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		sleep_mode = 1'b0;
		ot_trip    = 1'b0;
		last_res   = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_temp();
		t_refuse();
		conv(3'b001, 5'd0, 88, 88);
		conv(3'b101, 5'd10, 176, 176);
		conv(3'b010, 5'd20, 352, 352);
		conv(3'b110, 5'd5, 704, 704);
		sleep_mode <= 1'b1;
		conv(3'b011, 5'd7, 880, 884);
		sleep_mode <= 1'b0;
		t_abort();
		t_sleep();
		t_midreset();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
